// file: hw/jtag_prog_pkg.sv
package jtag_prog_pkg;

    localparam int IR_WIDTH   = 4;
    localparam int KEY_WIDTH  = 16;
    localparam int CMD_WIDTH  = 15;
    localparam int BYTE_WIDTH = 8;
    localparam int WORD_WIDTH = 16;
    localparam int ADDR_WIDTH = 16;
    localparam int LEN_WIDTH  = 5;

    // Instruction codes
    localparam logic [3:0] INSTR_DEVICE_RESET = 4'hc;
    localparam logic [3:0] INSTR_UNLOCK       = 4'h4;
    localparam logic [3:0] INSTR_COMMAND      = 4'h5;
    localparam logic [3:0] INSTR_PAGE_FILL    = 4'h6;
    localparam logic [3:0] INSTR_PAGE_FETCH   = 4'h7;
    localparam logic [3:0] INSTR_BYPASS       = 4'hf;
    localparam logic [3:0] IR_CAPTURE_VALUE   = 4'h1;

    localparam logic [15:0] UNLOCK_KEY        = 16'ha370;
    localparam logic [15:0] UNLOCK_RESET      = 16'h0000;

    // Chip clocks of external reset before the disable bit clears
    localparam int DISABLE_CLEAR_CLOCKS  = 2;
    // Default reset time-out in chip clocks
    localparam int RESET_TIMEOUT_CYCLES  = 16;
    // Longest allowed delay from Update-DR to page buffer write, in TCK
    localparam int PAGE_WRITE_MAX_TCK    = 11;
    // Host clock cycles per half TCK period
    localparam int TCK_HALF_CYCLES       = 4;
    localparam int TAP_RESET_ONES        = 5;

    typedef enum {
        TLR, RTI, SEL_DR, CAP_DR, SH_DR, EX1_DR, PA_DR, EX2_DR, UPD_DR,
        SEL_IR, CAP_IR, SH_IR, EX1_IR, PA_IR, EX2_IR, UPD_IR
    } tap_state_t;

    typedef enum logic [2:0] {
        OP_TAP_RESET, OP_SHIFT_IR, OP_SHIFT_DR, OP_SEND_KEY, OP_CLEAR_KEY
    } host_op_t;

    function automatic tap_state_t nextTap(tap_state_t s, logic tms);
        case (s)
            TLR:     nextTap = tms ? TLR    : RTI;
            RTI:     nextTap = tms ? SEL_DR : RTI;
            SEL_DR:  nextTap = tms ? SEL_IR : CAP_DR;
            CAP_DR:  nextTap = tms ? EX1_DR : SH_DR;
            SH_DR:   nextTap = tms ? EX1_DR : SH_DR;
            EX1_DR:  nextTap = tms ? UPD_DR : PA_DR;
            PA_DR:   nextTap = tms ? EX2_DR : PA_DR;
            EX2_DR:  nextTap = tms ? UPD_DR : SH_DR;
            UPD_DR:  nextTap = tms ? SEL_DR : RTI;
            SEL_IR:  nextTap = tms ? TLR    : CAP_IR;
            CAP_IR:  nextTap = tms ? EX1_IR : SH_IR;
            SH_IR:   nextTap = tms ? EX1_IR : SH_IR;
            EX1_IR:  nextTap = tms ? UPD_IR : PA_IR;
            PA_IR:   nextTap = tms ? EX2_IR : PA_IR;
            EX2_IR:  nextTap = tms ? UPD_IR : SH_IR;
            UPD_IR:  nextTap = tms ? SEL_DR : RTI;
            default: nextTap = TLR;
        endcase
    endfunction

endpackage

// file: hw/jtag_link_if.sv
`timescale 1ns/100ps
interface jtag_link_if;
    logic tck;
    logic tms;
    logic tdi;
    logic tdo;

    modport device (
        input  tck,
        input  tms,
        input  tdi,
        output tdo
    );

    modport host (
        output tck,
        output tms,
        output tdi,
        input  tdo
    );
endinterface

// file: hw/jtag_prog_port.sv
`timescale 1ns/100ps
module jtag_prog_port #(
    parameter int ADDR_WIDTH      = jtag_prog_pkg::ADDR_WIDTH,
    parameter int RESET_TIMEOUT   = jtag_prog_pkg::RESET_TIMEOUT_CYCLES
) (
    // Chip clock domain
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Test access port
    jtag_link_if.device                link,
    // Port enable controls
    input  wire logic                  portEnableFuse,
    input  wire logic                  portDisableSet,
    input  wire logic                  extResetN,
    output logic                       portDisableBit,
    output logic                       chipReset,
    // Programming command path, TCK domain
    output logic [14:0]                cmdWord,
    output logic                       cmdStrobe,
    input  wire logic [14:0]           cmdResult,
    output logic                       progMode,
    // Page buffer path, TCK domain
    input  wire logic [ADDR_WIDTH-1:0] addrPreset,
    output logic [ADDR_WIDTH-1:0]      memAddr,
    output logic [7:0]                 memWriteData,
    output logic                       memWriteHigh,
    output logic                       memWrite,
    input  wire logic [15:0]           memReadData
);
    localparam int CNT_W = $clog2(RESET_TIMEOUT + 1);

    // Chip clock domain
    logic             extSync1;
    logic             extSync2;
    logic [1:0]       extLowCnt;
    logic             resetSync1;
    logic             resetSync2;
    logic [CNT_W-1:0] timeoutCnt;
    logic             resetRequest;
    logic             linkRstHold;
    logic             ackSync1;
    logic             ackSync2;

    // TCK domain
    logic                   rstSync1;
    logic                   rstSync2;
    logic                   actSync1;
    logic                   actSync2;
    logic                   linkRst;
    jtag_prog_pkg::tap_state_t tap;
    logic [3:0]             irShift;
    logic [3:0]             ir;
    logic                   resetBit;
    logic                   bypassBit;
    logic [15:0]            unlockReg;
    logic [14:0]            cmdReg;
    logic                   execArm;
    logic                   fillHighNext;
    logic                   fillFirst;
    logic                   fetchHighNext;
    logic                   tdoReg;

    always_ff @(posedge clk) begin
        extSync1 <= extResetN;
        extSync2 <= extSync1;
        resetSync1 <= resetBit;
        resetSync2 <= resetSync1;
        ackSync1 <= rstSync2;
        ackSync2 <= ackSync1;
    end

    // Disable bit clears after external reset held low
    always_ff @(posedge clk) begin
        if (rst) begin
            extLowCnt <= 2'h0;
        end else if (extSync2) begin
            extLowCnt <= 2'h0;
        end else if (extLowCnt != 2'(jtag_prog_pkg::DISABLE_CLEAR_CLOCKS)) begin
            extLowCnt <= extLowCnt + 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            portDisableBit <= 1'b0;
        end else if (portDisableSet) begin
            portDisableBit <= 1'b1;
        end else if (extLowCnt == 2'(jtag_prog_pkg::DISABLE_CLEAR_CLOCKS)) begin
            portDisableBit <= 1'b0;
        end
    end

    assign resetRequest = resetSync2 | ~extSync2;

    // Reset time-out after the reset source goes away
    always_ff @(posedge clk) begin
        if (rst || resetRequest) begin
            timeoutCnt <= CNT_W'(RESET_TIMEOUT);
        end else if (timeoutCnt != '0) begin
            timeoutCnt <= timeoutCnt - CNT_W'(1);
        end
    end

    // Reset bit acts directly, not through the synchroniser
    assign chipReset = resetBit | resetRequest | (timeoutCnt != '0);

    // Reset held until the TCK side has seen it; TCK may be stopped
    always_ff @(posedge clk) begin
        if (rst) begin
            linkRstHold <= 1'b1;
        end else if (ackSync2) begin
            linkRstHold <= 1'b0;
        end
    end

    // Crossings into the TCK domain
    always_ff @(posedge link.tck) begin
        rstSync1 <= linkRstHold;
        rstSync2 <= rstSync1;
        actSync1 <= portEnableFuse & ~portDisableBit;
        actSync2 <= actSync1;
    end

    assign linkRst = rstSync2 | ~actSync2;

    // TAP controller; only TMS, TCK, TDI and TDO are used
    always_ff @(posedge link.tck) begin
        if (linkRst) begin
            tap <= jtag_prog_pkg::TLR;
        end else begin
            tap <= jtag_prog_pkg::nextTap(tap, link.tms);
        end
    end

    // Instruction register
    always_ff @(posedge link.tck) begin
        if (linkRst || tap == jtag_prog_pkg::TLR) begin
            irShift <= jtag_prog_pkg::INSTR_BYPASS;
            ir      <= jtag_prog_pkg::INSTR_BYPASS;
        end else begin
            case (tap)
                jtag_prog_pkg::CAP_IR: irShift <= jtag_prog_pkg::IR_CAPTURE_VALUE;
                jtag_prog_pkg::SH_IR:  irShift <= {link.tdi, irShift[3:1]};
                jtag_prog_pkg::UPD_IR: ir      <= irShift;
                default: ;
            endcase
        end
    end

    // Reset and bypass registers; TAP itself is not reset here
    always_ff @(posedge link.tck) begin
        if (linkRst) begin
            resetBit  <= 1'b0;
            bypassBit <= 1'b0;
        end else if (tap == jtag_prog_pkg::SH_DR) begin
            if (ir == jtag_prog_pkg::INSTR_DEVICE_RESET) begin
                resetBit <= link.tdi;
            end
            bypassBit <= link.tdi;
        end else if (tap == jtag_prog_pkg::CAP_DR) begin
            bypassBit <= 1'b0;
        end
    end

    // Unlock register and programming mode
    always_ff @(posedge link.tck) begin
        if (rstSync2) begin
            unlockReg <= jtag_prog_pkg::UNLOCK_RESET;
            progMode  <= 1'b0;
        end else if (linkRst) begin
            progMode  <= 1'b0;
        end else if (ir == jtag_prog_pkg::INSTR_UNLOCK) begin
            if (tap == jtag_prog_pkg::SH_DR) begin
                unlockReg <= {link.tdi, unlockReg[15:1]};
            end else if (tap == jtag_prog_pkg::UPD_DR) begin
                progMode <= (unlockReg == jtag_prog_pkg::UNLOCK_KEY);
            end
        end
    end

    // Command register, low byte doubles as the data byte register
    always_ff @(posedge link.tck) begin
        if (linkRst) begin
            cmdReg <= '0;
        end else if (tap == jtag_prog_pkg::CAP_DR && progMode) begin
            if (ir == jtag_prog_pkg::INSTR_COMMAND) begin
                cmdReg <= cmdResult;
            end else if (ir == jtag_prog_pkg::INSTR_PAGE_FETCH) begin
                cmdReg[7:0] <= fetchHighNext ? memReadData[15:8]
                                             : memReadData[7:0];
            end
        end else if (tap == jtag_prog_pkg::SH_DR) begin
            if (ir == jtag_prog_pkg::INSTR_COMMAND) begin
                cmdReg <= {link.tdi, cmdReg[14:1]};
            end else if (ir == jtag_prog_pkg::INSTR_PAGE_FILL ||
                         ir == jtag_prog_pkg::INSTR_PAGE_FETCH) begin
                cmdReg[7:0] <= {link.tdi, cmdReg[7:1]};
            end
        end
    end

    // Command apply and execute clock
    always_ff @(posedge link.tck) begin
        if (linkRst) begin
            cmdWord   <= '0;
            execArm   <= 1'b0;
            cmdStrobe <= 1'b0;
        end else begin
            cmdStrobe <= 1'b0;
            if (tap == jtag_prog_pkg::UPD_DR && progMode &&
                ir == jtag_prog_pkg::INSTR_COMMAND) begin
                cmdWord <= cmdReg;
                execArm <= 1'b1;
            end else if (tap == jtag_prog_pkg::RTI && execArm) begin
                cmdStrobe <= 1'b1;
                execArm   <= 1'b0;
            end
        end
    end

    // Page fill and fetch sequencing
    always_ff @(posedge link.tck) begin
        if (linkRst) begin
            memAddr       <= '0;
            memWriteData  <= '0;
            memWriteHigh  <= 1'b0;
            memWrite      <= 1'b0;
            fillHighNext  <= 1'b0;
            fillFirst     <= 1'b1;
            fetchHighNext <= 1'b0;
        end else begin
            memWrite <= 1'b0;
            if (tap == jtag_prog_pkg::UPD_IR) begin
                memAddr       <= addrPreset;
                fillHighNext  <= 1'b0;
                fillFirst     <= 1'b1;
                fetchHighNext <= 1'b0;
            end else if (tap == jtag_prog_pkg::UPD_DR && progMode &&
                         ir == jtag_prog_pkg::INSTR_PAGE_FILL) begin
                memWriteData <= cmdReg[7:0];
                memWriteHigh <= fillHighNext;
                memWrite     <= 1'b1;
                fillHighNext <= ~fillHighNext;
                fillFirst    <= 1'b0;
                if (!fillHighNext && !fillFirst) begin
                    memAddr <= memAddr + ADDR_WIDTH'(1);
                end
            end else if (tap == jtag_prog_pkg::CAP_DR && progMode &&
                         ir == jtag_prog_pkg::INSTR_PAGE_FETCH) begin
                fetchHighNext <= ~fetchHighNext;
                if (fetchHighNext) begin
                    memAddr <= memAddr + ADDR_WIDTH'(1);
                end
            end
        end
    end

    // TDO changes on the falling TCK edge
    always_ff @(negedge link.tck) begin
        if (tap == jtag_prog_pkg::SH_IR) begin
            tdoReg <= irShift[0];
        end else if (tap == jtag_prog_pkg::SH_DR) begin
            case (ir)
                jtag_prog_pkg::INSTR_DEVICE_RESET: tdoReg <= resetBit;
                jtag_prog_pkg::INSTR_UNLOCK:       tdoReg <= unlockReg[0];
                jtag_prog_pkg::INSTR_COMMAND,
                jtag_prog_pkg::INSTR_PAGE_FILL,
                jtag_prog_pkg::INSTR_PAGE_FETCH:   tdoReg <= cmdReg[0];
                default:                           tdoReg <= bypassBit;
            endcase
        end else begin
            tdoReg <= 1'b0;
        end
    end

    assign link.tdo = tdoReg;
endmodule

// file: hw/jtag_programmer.sv
`timescale 1ns/100ps
module jtag_programmer #(
    parameter int TCK_HALF = jtag_prog_pkg::TCK_HALF_CYCLES
) (
    // Clock and reset
    input  wire logic                  clk,
    input  wire logic                  rst,
    // Test access port
    jtag_link_if.host                  link,
    // Request
    input  wire logic                  reqValid,
    output logic                       reqReady,
    input  wire jtag_prog_pkg::host_op_t reqKind,
    input  wire logic [4:0]            reqLen,
    input  wire logic [15:0]           reqData,
    // Answer
    output logic                       rspValid,
    output logic                       rspRefused,
    output logic [15:0]                rspData
);
    localparam int DIV_W = $clog2(TCK_HALF + 1);

    logic [DIV_W-1:0] divCnt;
    logic             busy;
    logic             ending;
    logic             tckReg;
    logic             tmsReg;
    logic             tdiReg;
    logic             tdoSync1;
    logic             tdoSync2;
    logic [5:0]       preVec;
    logic [2:0]       preLen;
    logic [4:0]       shLen;
    logic [1:0]       postLen;
    logic [5:0]       step;
    logic [15:0]      txData;
    logic [15:0]      rxData;
    logic [3:0]       lastIr;
    logic             resetSeen;
    logic             opIsDr;
    logic             wrap;
    logic             riseEvt;
    logic             fallEvt;
    logic [5:0]       total;
    logic [5:0]       shStart;

    function automatic logic tmsAt(logic [5:0] s, logic [5:0] vec,
                                   logic [2:0] pl, logic [4:0] sl);
        logic [5:0] rel;
        rel = s - 6'(pl);
        if (s < 6'(pl)) begin
            tmsAt = vec[s[2:0]];
        end else if (rel < 6'(sl)) begin
            tmsAt = (rel == 6'(sl) - 6'h1);
        end else begin
            tmsAt = (rel == 6'(sl));
        end
    endfunction

    assign reqReady = ~busy;
    assign wrap     = busy && (divCnt == DIV_W'(TCK_HALF - 1));
    assign riseEvt  = wrap && !tckReg;
    assign fallEvt  = wrap && tckReg;
    assign total    = 6'(preLen) + 6'(shLen) + 6'(postLen);
    assign shStart  = 6'(preLen);

    always_ff @(posedge clk) begin
        tdoSync1 <= link.tdo;
        tdoSync2 <= tdoSync1;
    end

    // TCK divider
    always_ff @(posedge clk) begin
        if (rst || !busy) begin
            divCnt <= '0;
            tckReg <= 1'b0;
        end else if (wrap) begin
            divCnt <= '0;
            tckReg <= ~tckReg;
        end else begin
            divCnt <= divCnt + DIV_W'(1);
        end
    end

    // Request accept, sequencing and answer
    always_ff @(posedge clk) begin
        if (rst) begin
            busy       <= 1'b0;
            ending     <= 1'b0;
            tmsReg     <= 1'b1;
            tdiReg     <= 1'b0;
            preVec     <= '0;
            preLen     <= '0;
            shLen      <= '0;
            postLen    <= '0;
            step       <= '0;
            txData     <= '0;
            rxData     <= '0;
            opIsDr     <= 1'b0;
            rspValid   <= 1'b0;
            rspRefused <= 1'b0;
            rspData    <= '0;
        end else begin
            rspValid   <= 1'b0;
            rspRefused <= 1'b0;
            if (!busy && reqValid) begin
                step    <= '0;
                ending  <= 1'b0;
                rxData  <= '0;
                opIsDr  <= (reqKind == jtag_prog_pkg::OP_SHIFT_DR);
                postLen <= 2'h2;
                shLen   <= reqLen;
                txData  <= reqData;
                preVec  <= 6'h01;
                preLen  <= 3'h3;
                case (reqKind)
                    jtag_prog_pkg::OP_TAP_RESET: begin
                        preVec  <= 6'h1f;
                        preLen  <= 3'(jtag_prog_pkg::TAP_RESET_ONES + 1);
                        shLen   <= '0;
                        postLen <= '0;
                    end
                    jtag_prog_pkg::OP_SHIFT_IR: begin
                        preVec <= 6'h03;
                        preLen <= 3'h4;
                        shLen  <= 5'(jtag_prog_pkg::IR_WIDTH);
                    end
                    jtag_prog_pkg::OP_SEND_KEY: begin
                        txData <= jtag_prog_pkg::UNLOCK_KEY;
                        shLen  <= 5'(jtag_prog_pkg::KEY_WIDTH);
                    end
                    jtag_prog_pkg::OP_CLEAR_KEY: begin
                        txData <= jtag_prog_pkg::UNLOCK_RESET;
                        shLen  <= 5'(jtag_prog_pkg::KEY_WIDTH);
                    end
                    default: ;
                endcase
                if (reqKind == jtag_prog_pkg::OP_SEND_KEY && !resetSeen) begin
                    rspValid   <= 1'b1;
                    rspRefused <= 1'b1;
                end else begin
                    busy   <= 1'b1;
                    tmsReg <= 1'b1;
                    tdiReg <= (reqKind == jtag_prog_pkg::OP_SEND_KEY) ?
                              jtag_prog_pkg::UNLOCK_KEY[0] : reqData[0];
                end
            end else if (riseEvt) begin
                if (step >= shStart && step < shStart + 6'(shLen)) begin
                    rxData <= {tdoSync2, rxData[15:1]};
                    txData <= {1'b0, txData[15:1]};
                end
                step <= step + 6'h1;
                if (step + 6'h1 == total) begin
                    ending <= 1'b1;
                end
            end else if (fallEvt) begin
                if (ending) begin
                    busy     <= 1'b0;
                    rspValid <= 1'b1;
                    rspData  <= rxData >> (5'h10 - shLen);
                end else begin
                    tmsReg <= tmsAt(step, preVec, preLen, shLen);
                    tdiReg <= txData[0];
                end
            end
        end
    end

    // Device reset seen before unlocking
    always_ff @(posedge clk) begin
        if (rst) begin
            lastIr    <= jtag_prog_pkg::INSTR_BYPASS;
            resetSeen <= 1'b0;
        end else if (fallEvt && ending) begin
            if (opIsDr && lastIr == jtag_prog_pkg::INSTR_DEVICE_RESET) begin
                resetSeen <= 1'b1;
            end
        end else if (!busy && reqValid &&
                     reqKind == jtag_prog_pkg::OP_SHIFT_IR) begin
            lastIr <= reqData[3:0];
        end
    end

    assign link.tck = tckReg;
    assign link.tms = tmsReg;
    assign link.tdi = tdiReg;
endmodule

// file: test/jtag_memory_programming_port_monitor.sv
`timescale 1ns/100ps
module jtag_memory_programming_port_monitor (
    // Chip clock and reset
    input wire logic clk,
    input wire logic rst,
    // Link
    input wire logic tck,
    input wire logic tms,
    input wire logic tdi,
    input wire logic tdo
);
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    a_reset_link_idle: assert property ($fell(rst) |-> !tck && tms)
        else $error("link not idle after reset");
    a_tck_high_phase: assert property ($rose(tck) |-> tck[*4] ##1 !tck)
        else $error("tck high phase wrong");
    a_tck_low_phase: assert property ($fell(tck) |-> !tck[*4])
        else $error("tck low phase short");
    a_tck_low_before: assert property ($rose(tck) |-> !$past(tck, 4))
        else $error("tck low before rise short");
    a_tms_change_low: assert property ($changed(tms) |-> !tck)
        else $error("tms moved while tck high");
    a_tdi_change_low: assert property ($changed(tdi) |-> !tck)
        else $error("tdi moved while tck high");
    a_tdo_on_fall: assert property ($changed(tdo) |-> $fell(tck))
        else $error("tdo moved off falling tck");
    a_tdo_hold: assert property ($fell(tck) |=> $stable(tdo)[*3])
        else $error("tdo not held");

    c_tck_pulse: cover property ($rose(tck));
    c_tdo_high: cover property ($rose(tdo));
    c_tms_rise: cover property ($rose(tck) && tms);
endmodule

// file: test/jtag_memory_programming_port_test.sv
`timescale 1ns/100ps
module jtag_memory_programming_port_test;
    logic                    clk, rst, disSet, extRstN, reqValid, reqReady;
    logic                    rspValid, rspRefused, disBit, chipReset, fuse;
    logic                    cmdStrobe, progMode, memWriteHigh, memWrite;
    logic [4:0]              reqLen;
    logic [7:0]              memWriteData;
    logic [14:0]             cmdWord, cmdResult;
    logic [15:0]             reqData, rspData, addrPreset, memAddr, memReadData;
    logic [24:0]             wlog [4];
    jtag_prog_pkg::host_op_t reqKind;
    int                      fails, checks, strobes, wr, i;

    jtag_link_if link ();
    assign memReadData = {memAddr[7:0] ^ 8'h5a, memAddr[7:0]};

    jtag_prog_port #(.RESET_TIMEOUT(4)) i_jtag_prog_port (
        .clk(clk), .rst(rst), .link(link), .portEnableFuse(fuse),
        .portDisableSet(disSet), .extResetN(extRstN),
        .portDisableBit(disBit), .chipReset(chipReset), .cmdWord(cmdWord),
        .cmdStrobe(cmdStrobe), .cmdResult(cmdResult), .progMode(progMode),
        .addrPreset(addrPreset), .memAddr(memAddr),
        .memWriteData(memWriteData), .memWriteHigh(memWriteHigh),
        .memWrite(memWrite), .memReadData(memReadData));
    jtag_programmer i_jtag_programmer (
        .clk(clk), .rst(rst), .link(link), .reqValid(reqValid),
        .reqReady(reqReady), .reqKind(reqKind), .reqLen(reqLen),
        .reqData(reqData), .rspValid(rspValid), .rspRefused(rspRefused),
        .rspData(rspData));
    jtag_memory_programming_port_monitor i_jtag_memory_programming_port_monitor (
        .clk(clk), .rst(rst), .tck(link.tck), .tms(link.tms),
        .tdi(link.tdi), .tdo(link.tdo));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    // Pulses seen on the test clock
    always @(posedge link.tck) begin
        if (cmdStrobe === 1'b1)
            strobes++;
        if (memWrite === 1'b1 && wr < 4) begin
            wlog[wr] = {memAddr, memWriteHigh, memWriteData};
            wr++;
        end
    end

    task automatic summarize();
        $display("checks %0d fails %0d", checks, fails);
        if (fails == 0 && checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic chk(input string name, input logic [24:0] exp, got);
        checks++;
        if (exp !== got) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic req(input jtag_prog_pkg::host_op_t k,
                       input logic [4:0] n, input logic [15:0] d);
        int t;
        @(negedge clk);
        reqKind = k;
        reqLen = n;
        reqData = d;
        reqValid = 1'b1;
        for (t = 0; t < 200 && reqReady !== 1'b1; t++) @(negedge clk);
        if (t >= 200) begin
            fails++;
            summarize();
        end
        @(posedge clk);
        @(negedge clk);
        reqValid = 1'b0;
        for (t = 0; t < 3000 && rspValid !== 1'b1; t++) @(negedge clk);
        if (t >= 3000) begin
            fails++;
            summarize();
        end
    endtask

    task automatic ir(input logic [3:0] code);
        req(jtag_prog_pkg::OP_SHIFT_IR, 5'h04, {12'h000, code});
        chk("ir capture", jtag_prog_pkg::IR_CAPTURE_VALUE, rspData[3:0]);
    endtask

    initial begin
        {rst, disSet, extRstN, reqValid, fuse} = 5'h15;
        {reqKind, reqLen, reqData} = '0;
        {strobes, wr, fails, checks} = '0;
        cmdResult = 15'h5a5a;
        addrPreset = 16'h0010;
        repeat (10) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        req(jtag_prog_pkg::OP_TAP_RESET, 5'h00, 16'h0000);
        req(jtag_prog_pkg::OP_SEND_KEY, 5'h10, 16'ha370);
        chk("early key refused", 1'b1, rspRefused);
        ir(jtag_prog_pkg::INSTR_DEVICE_RESET);
        req(jtag_prog_pkg::OP_SHIFT_DR, 5'h01, 16'h0001);
        chk("chipReset held", 1'b1, chipReset);
        req(jtag_prog_pkg::OP_SHIFT_DR, 5'h01, 16'h0000);
        chk("chipReset released", 1'b0, chipReset);
        ir(jtag_prog_pkg::INSTR_COMMAND);
        req(jtag_prog_pkg::OP_SHIFT_DR, 5'h0f, 16'h0777);
        ir(jtag_prog_pkg::INSTR_UNLOCK);
        chk("locked strobes", 0, strobes);
        req(jtag_prog_pkg::OP_SHIFT_DR, 5'h10, 16'b1010_0011_0111_0001);
        chk("wrong key", 1'b0, progMode);
        req(jtag_prog_pkg::OP_SHIFT_DR, 5'h10, 16'b1010_0011_0111_0000);
        chk("right key", 1'b1, progMode);
        ir(jtag_prog_pkg::INSTR_COMMAND);
        req(jtag_prog_pkg::OP_SHIFT_DR, 5'h0f, 16'h1234);
        chk("cmd result", 15'h5a5a, rspData[14:0]);
        chk("cmd word", 15'h1234, cmdWord);
        ir(jtag_prog_pkg::INSTR_PAGE_FILL);
        chk("exec strobes", 1, strobes);
        for (i = 0; i < 4; i++)
            req(jtag_prog_pkg::OP_SHIFT_DR, 5'h08, 16'h0011 * (i + 1));
        @(negedge clk) addrPreset = 16'h0020;
        ir(jtag_prog_pkg::INSTR_PAGE_FETCH);
        chk("write count", 4, wr);
        for (i = 0; i < 4; i++)
            chk("page write", {16'(16'h0010 + i / 2), i[0],
                8'(8'h11 * (i + 1))}, wlog[i]);
        for (i = 0; i < 4; i++) begin
            req(jtag_prog_pkg::OP_SHIFT_DR, 5'h08, 16'h0000);
            chk("page read", (8'h20 + i / 2) ^ (i[0] ? 8'h5a : 8'h00),
                rspData[7:0]);
        end
        chk("read address", 16'h0022, memAddr);
        ir(jtag_prog_pkg::INSTR_UNLOCK);
        req(jtag_prog_pkg::OP_CLEAR_KEY, 5'h10, 16'hffff);
        chk("key cleared", 1'b0, progMode);
        req(jtag_prog_pkg::OP_SEND_KEY, 5'h10, 16'h0000);
        chk("key accepted", 1'b0, rspRefused);
        chk("sent key", 1'b1, progMode);
        fuse = 1'b0;
        req(jtag_prog_pkg::OP_SHIFT_IR, 5'h04, 16'h0005);
        chk("fuse off", 4'h0, rspData[3:0]);
        fuse = 1'b1;
        @(negedge clk) disSet = 1'b1;
        @(negedge clk) disSet = 1'b0;
        chk("disable set", 1'b1, disBit);
        extRstN = 1'b0;
        repeat (8) @(negedge clk);
        chk("disable cleared", 1'b0, disBit);
        chk("ext reset", 1'b1, chipReset);
        summarize();
    end
endmodule
